// ===== src/vxi_cfg_pkg.sv
// shared constants, types and helpers of the power-on configuration block
package vxi_cfg_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] word_t;
  typedef logic [DATA_W/8-1:0] strb_t;
  typedef logic [1:0] resp_t;
  localparam resp_t RESP_OKAY = 2'h0;
  localparam resp_t RESP_SLVERR = 2'h2;

  // image: words 0..3 pci side, 4..7 vxibus side
  localparam int SIDE_WORDS = 4;
  localparam int IMAGE_WORDS = 8;
  localparam int IDX_W = 3;
  localparam int MEM_ADDR_W = 4;
  localparam int SIDE_BIT = 2;
  typedef logic [IDX_W-1:0] idx_t;
  typedef logic [MEM_ADDR_W-1:0] mem_addr_t;
  typedef logic [SIDE_WORDS*DATA_W-1:0] side_regs_t;
  localparam idx_t LAST_IDX = 3'h7;
  localparam logic USER_HALF = 1'h0;
  localparam logic FACTORY_HALF = 1'h1;
  // factory image contents, values arbitrary
  localparam word_t FACTORY_IMAGE [IMAGE_WORDS] = '{
    32'h0000_0011, 32'h0000_0022, 32'h0000_0033, 32'h0000_0044,
    32'h0000_0055, 32'h0000_0066, 32'h0000_0077, 32'h0000_0088};

  localparam addr_t CONTROL_OFS = 8'h00;
  localparam addr_t STATUS_OFS = 8'h04;
  localparam addr_t CFG_ADDR_OFS = 8'h08;
  localparam addr_t CFG_DATA_OFS = 8'h0C;
  localparam addr_t PCI_REGS_OFS = 8'h20;
  localparam addr_t VXI_REGS_OFS = 8'h30;
  localparam int WIN_LSB = 4;
  localparam int CTRL_ROUTE_BIT = 0;
  localparam word_t CONTROL_RESET = 32'h0000_0000;
  localparam idx_t CFG_ADDR_RESET = 3'h0;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_OFF_BIT = 1;
  localparam int ST_SYSCON_BIT = 2;
  localparam int ST_SLOT0_BIT = 3;
  localparam int ST_FACTORY_BIT = 4;
  localparam int ST_LATE_BIT = 5;
  localparam int ST_CLK10_EXT_BIT = 6;
  localparam int ST_BUSY_BIT = 7;

  // jumper positions that are the defaults
  localparam logic POWER_ON_SELF_CONFIG_ENABLED = 1'h0;
  localparam logic HALF_USER_POS = 1'h0;
  typedef enum logic [1:0] {
    ROLE_AUTO = 2'h0,
    ROLE_NON_SYS = 2'h1,
    ROLE_FORCE_SYS = 2'h2
  } role_sel_t;
  localparam int PIN_W = 10;
  localparam logic [PIN_W-1:0] PIN_SYNC_RESET = 10'h000;

  typedef enum logic [4:0] {
    LD_WAIT = 5'h01,
    LD_READ = 5'h02,
    LD_STORE = 5'h04,
    LD_DONE = 5'h08,
    LD_OFF = 5'h10
  } load_state_t;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  localparam int REF_CLK_HZ = 25_000_000;
  localparam int READY_LIMIT_S = 5;
  localparam int unsigned READY_LIMIT_CYCLES_DEF = READY_LIMIT_S * REF_CLK_HZ;

  localparam int NUM_LEVELS = 4;
  typedef logic [NUM_LEVELS-1:0] level_t;

  function automatic level_t pick_highest(input level_t req);
    level_t g;
    g = '0;
    for (int i = 0; i < NUM_LEVELS; i++)
    begin
      if (req[i])
      begin
        g = '0;
        g[i] = 1'h1;
      end
    end
    return g;
  endfunction

  function automatic addr_t word_align(input addr_t a);
    return {a[ADDR_W-1:2], 2'h0};
  endfunction

  function automatic logic reg_mapped(input addr_t a);
    addr_t al;
    al = word_align(a);
    return al == CONTROL_OFS || al == STATUS_OFS || al == CFG_ADDR_OFS ||
      al == CFG_DATA_OFS ||
      al[ADDR_W-1:WIN_LSB] == PCI_REGS_OFS[ADDR_W-1:WIN_LSB] ||
      al[ADDR_W-1:WIN_LSB] == VXI_REGS_OFS[ADDR_W-1:WIN_LSB];
  endfunction

  function automatic word_t side_word(input side_regs_t r,
                                      input logic [1:0] sel);
    return r[sel*DATA_W +: DATA_W];
  endfunction
endpackage

// ===== src/cfg_mem_if.sv
// link between the loader and the two-half configuration image store
`timescale 1ns/1ps
interface cfg_mem_if;
  import vxi_cfg_pkg::*;
  logic rd_en;
  mem_addr_t rd_addr;
  word_t rd_data;
  logic wr_en;
  idx_t wr_idx;
  word_t wr_data;
  modport loader (output rd_en, rd_addr, wr_en, wr_idx, wr_data,
                  input rd_data);
  modport store (input rd_en, rd_addr, wr_en, wr_idx, wr_data,
                 output rd_data);
endinterface

// ===== src/cfg_image_store.sv
// two-half configuration image: fixed factory half, writable user half
`timescale 1ns/1ps
module cfg_image_store
(
  input wire logic ref_clk,
  input wire logic reset,
  cfg_mem_if.store mem
);
  import vxi_cfg_pkg::*;

  word_t user_half [IMAGE_WORDS];

  // user half starts as a copy of the factory half
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < IMAGE_WORDS; i++)
        user_half[i] <= FACTORY_IMAGE[i];
    end
    else if (mem.wr_en)
      user_half[mem.wr_idx] <= mem.wr_data;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      mem.rd_data <= '0;
    else if (mem.rd_en)
    begin
      if (mem.rd_addr[IDX_W] == FACTORY_HALF)
        mem.rd_data <= FACTORY_IMAGE[mem.rd_addr[IDX_W-1:0]];
      else
        mem.rd_data <= user_half[mem.rd_addr[IDX_W-1:0]];
    end
  end
endmodule

// ===== src/dtb_arbiter.sv
// four-level priority arbiter for the data transfer bus
`timescale 1ns/1ps
module dtb_arbiter
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic enable,
  input wire vxi_cfg_pkg::level_t request,
  output vxi_cfg_pkg::level_t grant
);
  import vxi_cfg_pkg::*;

  // hold a grant while its request stays, then rank afresh
  always_ff @(posedge ref_clk)
  begin
    if (reset || !enable)
      grant <= '0;
    else if ((grant & request) == '0)
      grant <= pick_highest(request);
  end
endmodule

// ===== src/vxi_config_top.sv
// power-on configuration loader, slot role, arbiter and clock control
//
// What this block does
// - Load stored image into pci and vxibus registers
// - Interface ready within 5 s of reset release
// - Disable input suppresses the load; enabled by default
// - Image has factory and user halves, selectable
// - Default position loads user half; alternate factory
// - Role select: auto, forced controller, forced non-controller
// - Auto mode: slot 0 makes system controller
// - Controller arbitrates four request levels by priority
// - Drive 16 MHz system clock only as controller
// - Drive CLK10 only as system controller, else input only
// - Source select picks internal or external oscillator
// - Option routes backplane CLK10 to clock connector
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module vxi_config_top
#(
  parameter int unsigned READY_LIMIT_CYCLES =
    vxi_cfg_pkg::READY_LIMIT_CYCLES_DEF
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire vxi_cfg_pkg::addr_t s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire vxi_cfg_pkg::word_t s_axi_wdata,
  input wire vxi_cfg_pkg::strb_t s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output vxi_cfg_pkg::resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire vxi_cfg_pkg::addr_t s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output vxi_cfg_pkg::word_t s_axi_rdata,
  output vxi_cfg_pkg::resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic self_config_disable_select,
  input wire logic config_half_select,
  input wire logic [1:0] slot_role_select,
  input wire logic clock10_source_select,
  input wire logic slot0_sense,
  input wire vxi_cfg_pkg::level_t bus_request_n,
  output vxi_cfg_pkg::level_t bus_grant_n,
  output logic bus_grant_oe,
  output logic sysclk16_oe,
  output logic clk10_oe,
  output logic clk10_ext_select,
  output logic clk_connector_route,
  output logic vxi_slave_enable,
  output vxi_cfg_pkg::side_regs_t pci_cfg_regs,
  output vxi_cfg_pkg::side_regs_t vxi_cfg_regs
);
  import vxi_cfg_pkg::*;

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic slot0_s;
  logic disable_s;
  logic half_s;
  logic [1:0] role_s;
  logic clk_src_s;
  level_t req_s;

  logic syscon;
  level_t grant;

  load_state_t load_state;
  logic [1:0] settle_cnt;
  idx_t load_idx;
  logic half_sel;
  logic [31:0] deadline_cnt;
  logic ready_late;

  logic aw_held;
  logic w_held;
  addr_t aw_addr_q;
  word_t w_data_q;
  strb_t w_strb_q;
  logic do_write;
  addr_t wr_al;
  resp_t write_resp;
  idx_t cfg_idx;
  word_t status_word;
  word_t rd_word;
  addr_t rd_al;

  cfg_mem_if mem ();

  // jumper, slot sense and request pins cross in from the backplane
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pin_meta <= PIN_SYNC_RESET;
      pin_sync <= PIN_SYNC_RESET;
    end
    else
    begin
      pin_meta <= {slot0_sense, self_config_disable_select,
                   config_half_select, slot_role_select,
                   clock10_source_select, ~bus_request_n};
      pin_sync <= pin_meta;
    end
  end

  assign {slot0_s, disable_s, half_s, role_s, clk_src_s, req_s} = pin_sync;

  // role choice; an unused jumper code falls back to detection
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      syscon <= 1'h0;
    else
    begin
      case (role_sel_t'(role_s))
        ROLE_AUTO: syscon <= slot0_s;
        ROLE_FORCE_SYS: syscon <= 1'h1;
        ROLE_NON_SYS: syscon <= 1'h0;
        default: syscon <= slot0_s;
      endcase
    end
  end

  dtb_arbiter arbiter
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .enable(syscon),
    .request(req_s),
    .grant(grant)
  );

  assign bus_grant_n = ~grant;
  assign bus_grant_oe = syscon;
  assign sysclk16_oe = syscon;
  assign clk10_oe = syscon;

  // clock source and connector routing follow their controls
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      clk10_ext_select <= 1'h0;
    else
      clk10_ext_select <= clk_src_s;
  end

  // loader sequence
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      load_state <= LD_WAIT;
    else
    begin
      case (load_state)
        LD_WAIT:
        begin
          if (settle_cnt == SETTLE_CYCLES)
          begin
            if (disable_s != POWER_ON_SELF_CONFIG_ENABLED)
              load_state <= LD_OFF;
            else
              load_state <= LD_READ;
          end
        end
        LD_READ: load_state <= LD_STORE;
        LD_STORE:
        begin
          if (load_idx == LAST_IDX)
            load_state <= LD_DONE;
          else
            load_state <= LD_READ;
        end
        LD_DONE: load_state <= LD_DONE;
        LD_OFF: load_state <= LD_OFF;
        default: load_state <= LD_WAIT;
      endcase
    end
  end

  // let the pin synchronisers fill before the jumpers are trusted
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      settle_cnt <= 2'h0;
    else if (load_state == LD_WAIT && settle_cnt != SETTLE_CYCLES)
      settle_cnt <= settle_cnt + 2'h1;
  end

  // half chosen once, as the load starts
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      half_sel <= USER_HALF;
    else if (load_state == LD_WAIT && settle_cnt == SETTLE_CYCLES)
    begin
      if (half_s == HALF_USER_POS)
        half_sel <= USER_HALF;
      else
        half_sel <= FACTORY_HALF;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      load_idx <= '0;
    else if (load_state == LD_STORE)
      load_idx <= load_idx + 3'h1;
  end

  assign mem.rd_en = load_state == LD_READ;
  assign mem.rd_addr = {half_sel, load_idx};

  // image words land in the pci side, then the vxibus side
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pci_cfg_regs <= '0;
      vxi_cfg_regs <= '0;
    end
    else if (load_state == LD_STORE)
    begin
      if (load_idx[SIDE_BIT] == 1'h0)
        pci_cfg_regs[load_idx[1:0]*DATA_W +: DATA_W] <= mem.rd_data;
      else
        vxi_cfg_regs[load_idx[1:0]*DATA_W +: DATA_W] <= mem.rd_data;
    end
  end

  // slave claims on the same edge that stores the last word
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      vxi_slave_enable <= 1'h0;
    else if (load_state == LD_STORE && load_idx == LAST_IDX)
      vxi_slave_enable <= 1'h1;
  end

  // watchdog on the ready deadline after reset release
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      deadline_cnt <= '0;
    else if (!vxi_slave_enable && load_state != LD_OFF &&
             deadline_cnt != READY_LIMIT_CYCLES)
      deadline_cnt <= deadline_cnt + 32'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ready_late <= 1'h0;
    else if (!vxi_slave_enable && deadline_cnt == READY_LIMIT_CYCLES)
      ready_late <= 1'h1;
  end

  cfg_image_store image
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .mem(mem.store)
  );

  // register bus: write address and data are taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_al = word_align(aw_addr_q);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      aw_held <= 1'h0;
      aw_addr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'h1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held <= 1'h0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      w_held <= 1'h0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'h1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else if (do_write)
      w_held <= 1'h0;
  end

  // image words go in whole; a partial word is refused
  always_comb
  begin
    write_resp = RESP_OKAY;
    if (!reg_mapped(aw_addr_q))
      write_resp = RESP_SLVERR;
    else if (wr_al == CFG_DATA_OFS && w_strb_q != '1)
      write_resp = RESP_SLVERR;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'h1;
      s_axi_bresp <= write_resp;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'h0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      clk_connector_route <= CONTROL_RESET[CTRL_ROUTE_BIT];
    else if (do_write && wr_al == CONTROL_OFS && w_strb_q[0])
      clk_connector_route <= w_data_q[CTRL_ROUTE_BIT];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      cfg_idx <= CFG_ADDR_RESET;
    else if (do_write && wr_al == CFG_ADDR_OFS && w_strb_q[0])
      cfg_idx <= w_data_q[IDX_W-1:0];
  end

  // only the user half can be rewritten
  assign mem.wr_en = do_write && wr_al == CFG_DATA_OFS && w_strb_q == '1;
  assign mem.wr_idx = cfg_idx;
  assign mem.wr_data = w_data_q;

  always_comb
  begin
    status_word = '0;
    status_word[ST_DONE_BIT] = vxi_slave_enable;
    status_word[ST_OFF_BIT] = load_state == LD_OFF;
    status_word[ST_SYSCON_BIT] = syscon;
    status_word[ST_SLOT0_BIT] = slot0_s;
    status_word[ST_FACTORY_BIT] = half_sel == FACTORY_HALF;
    status_word[ST_LATE_BIT] = ready_late;
    status_word[ST_CLK10_EXT_BIT] = clk10_ext_select;
    status_word[ST_BUSY_BIT] = load_state == LD_READ ||
                               load_state == LD_STORE;
  end

  always_comb
  begin
    rd_word = '0;
    rd_al = word_align(s_axi_araddr);
    if (rd_al == CONTROL_OFS)
      rd_word[CTRL_ROUTE_BIT] = clk_connector_route;
    else if (rd_al == STATUS_OFS)
      rd_word = status_word;
    else if (rd_al == CFG_ADDR_OFS)
      rd_word[IDX_W-1:0] = cfg_idx;
    else if (rd_al[ADDR_W-1:WIN_LSB] == PCI_REGS_OFS[ADDR_W-1:WIN_LSB])
      rd_word = side_word(pci_cfg_regs, rd_al[3:2]);
    else if (rd_al[ADDR_W-1:WIN_LSB] == VXI_REGS_OFS[ADDR_W-1:WIN_LSB])
      rd_word = side_word(vxi_cfg_regs, rd_al[3:2]);
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'h1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'h0;
  end
endmodule

// ===== test/bp_model.sv
// backplane model: requesters on four levels and the slot position
`timescale 1ns/1ps
module bp_model
(
  input wire vxi_cfg_pkg::level_t want,
  input wire logic in_slot0,
  output vxi_cfg_pkg::level_t bus_request_n,
  output logic slot0_sense
);
  import vxi_cfg_pkg::*;
  // open-collector request lines, idle high through the pull-ups
  assign bus_request_n = ~want;
  assign slot0_sense = in_slot0;
endmodule

// ===== test/vxi_config_checker.sv
// assertion checker for the power-on configuration block
`timescale 1ns/1ps
module vxi_config_checker
#(
  parameter int unsigned READY_LIMIT_CYCLES = 64
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic self_config_disable_select,
  input wire logic [1:0] slot_role_select,
  input wire logic clock10_source_select,
  input wire logic slot0_sense,
  input wire vxi_cfg_pkg::level_t bus_request_n,
  input wire vxi_cfg_pkg::level_t bus_grant_n,
  input wire logic bus_grant_oe,
  input wire logic sysclk16_oe,
  input wire logic clk10_oe,
  input wire logic clk10_ext_select,
  input wire logic vxi_slave_enable,
  input wire vxi_cfg_pkg::side_regs_t pci_cfg_regs,
  input wire vxi_cfg_pkg::side_regs_t vxi_cfg_regs
);
  import vxi_cfg_pkg::*;
  int unsigned since_rel;
  // cycles since reset release, saturating past the limit
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      since_rel <= 0;
    else if (since_rel <= READY_LIMIT_CYCLES)
      since_rel <= since_rel + 1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  grant_onehot_a: assert property (
    bus_grant_oe |-> $onehot0(~bus_grant_n))
    else $error("more than one grant");
  grant_idle_a: assert property (
    !bus_grant_oe && $past(!bus_grant_oe) |-> bus_grant_n == 4'hF)
    else $error("grant given while not controller");
  grant_valid_a: assert property (
    $stable(bus_request_n)[*5] |-> (~bus_grant_n & bus_request_n) == 4'h0)
    else $error("grant to an idle level");
  clock_drive_a: assert property (
    $stable({slot_role_select, slot0_sense})[*6] |->
      sysclk16_oe == clk10_oe && clk10_oe ==
      (slot_role_select == 2'h2 || (slot_role_select != 2'h1 && slot0_sense)))
    else $error("clock drivers disagree with role");
  role_follow_a: assert property (
    $stable({slot_role_select, slot0_sense})[*6] |-> bus_grant_oe ==
      (slot_role_select == 2'h2 || (slot_role_select != 2'h1 && slot0_sense)))
    else $error("role does not follow select and slot");
  clk_source_a: assert property (
    $stable(clock10_source_select)[*6] |->
      clk10_ext_select == clock10_source_select)
    else $error("clk10 source does not follow select");
  slave_sticky_a: assert property (
    vxi_slave_enable |=> vxi_slave_enable)
    else $error("slave enable dropped");
  regs_settled_a: assert property (
    vxi_slave_enable && $past(vxi_slave_enable) |->
      $stable(pci_cfg_regs) && $stable(vxi_cfg_regs))
    else $error("loaded registers moved after enable");
  ready_time_a: assert property (
    since_rel == READY_LIMIT_CYCLES && !self_config_disable_select
      |-> vxi_slave_enable)
    else $error("interface not ready in time");
  load_off_a: assert property (
    since_rel == READY_LIMIT_CYCLES && self_config_disable_select
      |-> !vxi_slave_enable)
    else $error("interface enabled with load disabled");
endmodule

bind vxi_config_top vxi_config_checker
  #(.READY_LIMIT_CYCLES(READY_LIMIT_CYCLES)) u_chk (.ref_clk, .reset,
  .self_config_disable_select, .slot_role_select, .clock10_source_select,
  .slot0_sense, .bus_request_n, .bus_grant_n, .bus_grant_oe, .sysclk16_oe,
  .clk10_oe, .clk10_ext_select, .vxi_slave_enable, .pci_cfg_regs,
  .vxi_cfg_regs);

// ===== test/vxi_config_top_tb_top.sv
// self-checking bench for the power-on configuration block
`timescale 1ns/1ps
module vxi_config_top_tb_top;
  import vxi_cfg_pkg::*;
  localparam int unsigned LIMIT = 64;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  word_t s_axi_wdata = 32'h0;
  strb_t s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  resp_t s_axi_bresp, s_axi_rresp;
  word_t s_axi_rdata;
  logic self_config_disable_select = 1'h0, config_half_select = 1'h0;
  logic clock10_source_select = 1'h0, in_slot0 = 1'h0, slot0_sense;
  logic [1:0] slot_role_select = 2'h0;
  level_t want = 4'h0, bus_request_n, bus_grant_n;
  logic bus_grant_oe, sysclk16_oe, clk10_oe, clk10_ext_select;
  logic clk_connector_route, vxi_slave_enable;
  side_regs_t pci_cfg_regs, vxi_cfg_regs;
  int n_errors = 0, n_compared = 0;

  always #20 ref_clk = ~ref_clk;

  vxi_config_top #(.READY_LIMIT_CYCLES(LIMIT)) i_dut (.ref_clk, .reset,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .self_config_disable_select,
    .config_half_select, .slot_role_select, .clock10_source_select,
    .slot0_sense, .bus_request_n, .bus_grant_n, .bus_grant_oe, .sysclk16_oe,
    .clk10_oe, .clk10_ext_select, .clk_connector_route, .vxi_slave_enable,
    .pci_cfg_regs, .vxi_cfg_regs);
  bp_model i_bp (.want, .in_slot0, .bus_request_n, .slot0_sense);

  task automatic complete_run;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input word_t got, input word_t exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic axi_write(input addr_t a, input word_t d, output resp_t r);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    b_hs = 1'h0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b_hs && n < 100)
    begin
      @(negedge ref_clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid === 1'h1;
      r = s_axi_bresp;
      n++;
      @(posedge ref_clk);
      if (aw_hs)
        s_axi_awvalid <= 1'h0;
      if (w_hs)
        s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    chk1(b_hs, 1'h1, "write answer");
  endtask

  task automatic axi_read(input addr_t a, output word_t d, output resp_t r);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    r_hs = 1'h0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r_hs && n < 100)
    begin
      @(negedge ref_clk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid === 1'h1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      n++;
      @(posedge ref_clk);
      if (ar_hs)
        s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    chk1(r_hs, 1'h1, "read answer");
  endtask

  task automatic do_reset(input logic dis, input logic half);
    @(posedge ref_clk);
    reset <= 1'h1;
    self_config_disable_select <= dis;
    config_half_select <= half;
    repeat (5) @(posedge ref_clk);
    reset <= 1'h0;
  endtask

  task automatic t_load(input logic half);
    word_t d;
    resp_t r;
    int n;
    do_reset(1'h0, half);
    n = 0;
    while (vxi_slave_enable !== 1'h1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk1(n < LIMIT, 1'h1, "ready time");
    chk1(n > 15, 1'h1, "enable before load end");
    for (int k = 0; k < SIDE_WORDS; k++)
    begin
      chk(pci_cfg_regs[32*k +: 32], FACTORY_IMAGE[k], "pci word");
      chk(vxi_cfg_regs[32*k +: 32], FACTORY_IMAGE[k+4], "vxi word");
    end
    axi_read(STATUS_OFS, d, r);
    chk1(d[ST_DONE_BIT], 1'h1, "loaded flag");
    chk1(d[ST_FACTORY_BIT], half, "half used");
    chk1(d[ST_LATE_BIT], 1'h0, "late flag");
    axi_read(PCI_REGS_OFS + 8'h04, d, r);
    chk(d, FACTORY_IMAGE[1], "pci window");
    axi_read(VXI_REGS_OFS + 8'h0C, d, r);
    chk(d, FACTORY_IMAGE[7], "vxi window");
  endtask

  task automatic t_disabled;
    word_t d;
    resp_t r;
    do_reset(1'h1, USER_HALF);
    repeat (LIMIT + 8) @(negedge ref_clk);
    chk1(vxi_slave_enable, 1'h0, "enable with load off");
    axi_read(STATUS_OFS, d, r);
    chk1(d[ST_OFF_BIT], 1'h1, "off flag");
    chk1(d[ST_DONE_BIT], 1'h0, "loaded flag");
  endtask

  task automatic t_roles;
    logic e;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      slot_role_select <= i[2:1];
      in_slot0 <= i[0];
      repeat (8) @(negedge ref_clk);
      e = i[2:1] == 2'h2 || (i[2:1] != 2'h1 && i[0]);
      chk1(sysclk16_oe, e, "sysclk drive");
      chk1(clk10_oe, e, "clk10 drive");
      chk1(bus_grant_oe, e, "arbiter on");
    end
  endtask

  task automatic t_arb;
    for (int k = 3; k >= -1; k--)
    begin
      @(posedge ref_clk);
      slot_role_select <= 2'h2;
      want <= (k < 0) ? 4'h0 : level_t'(4'hF >> (3 - k));
      repeat (8) @(negedge ref_clk);
      chk(word_t'(bus_grant_n),
        word_t'(level_t'(k < 0 ? 4'hF : ~(4'h1 << k))), "grant");
    end
    @(posedge ref_clk);
    slot_role_select <= 2'h1;
    want <= 4'hF;
    repeat (8) @(negedge ref_clk);
    chk(word_t'(bus_grant_n), 32'h0000_000F, "grant off role");
    @(posedge ref_clk);
    want <= 4'h0;
  endtask

  task automatic t_clock;
    word_t d;
    resp_t r;
    for (int v = 1; v >= 0; v--)
    begin
      @(posedge ref_clk);
      clock10_source_select <= v[0];
      repeat (8) @(negedge ref_clk);
      chk1(clk10_ext_select, v[0], "clk10 source");
      axi_read(STATUS_OFS, d, r);
      chk1(d[ST_CLK10_EXT_BIT], v[0], "clk10 source flag");
    end
  endtask

  task automatic t_route;
    word_t d;
    resp_t r;
    for (int v = 1; v >= 0; v--)
    begin
      axi_write(CONTROL_OFS, word_t'(v), r);
      chk(word_t'(r), word_t'(RESP_OKAY), "control write");
      repeat (2) @(negedge ref_clk);
      chk1(clk_connector_route, v[0], "connector route");
      axi_read(CONTROL_OFS, d, r);
      chk(d, word_t'(v), "control readback");
    end
    axi_read(8'h80, d, r);
    chk(word_t'(r), word_t'(RESP_SLVERR), "unmapped read");
    chk(d, 32'h0000_0000, "unmapped data");
    axi_write(8'h80, 32'h0000_0001, r);
    chk(word_t'(r), word_t'(RESP_SLVERR), "unmapped write");
    axi_write(CFG_ADDR_OFS, 32'h0000_0005, r);
    chk(word_t'(r), word_t'(RESP_OKAY), "image index write");
    axi_read(CFG_ADDR_OFS, d, r);
    chk(d, 32'h0000_0005, "image index");
    s_axi_wstrb <= 4'h3;
    axi_write(CFG_DATA_OFS, 32'h0000_00AB, r);
    s_axi_wstrb <= 4'hF;
    chk(word_t'(r), word_t'(RESP_SLVERR), "partial image write");
    axi_write(CFG_DATA_OFS, 32'h0000_00AB, r);
    chk(word_t'(r), word_t'(RESP_OKAY), "image write");
  endtask

  initial
  begin
    t_load(USER_HALF);
    t_route();
    t_clock();
    t_roles();
    t_arb();
    t_disabled();
    t_load(FACTORY_HALF);
    complete_run();
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
